// ### logic/sleep_pkg.sv
package sleep_pkg;
  localparam logic [2:0]  MODE_IDLE    = 3'h0;
  localparam logic [2:0]  MODE_ADC_NR  = 3'h1;
  localparam logic [2:0]  MODE_PDOWN   = 3'h2;
  localparam logic [2:0]  MODE_PSAVE   = 3'h3;
  localparam logic [2:0]  MODE_STANDBY = 3'h6;
  localparam logic [11:0] ADDR_SLEEP_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CORE_CTRL  = 12'h004;
  localparam logic [11:0] ADDR_ASYNC_STAT = 12'h008;
  localparam logic [11:0] ADDR_STATUS     = 12'h00c;
  localparam int          BIT_ARM         = 0;
  localparam int          BIT_MODE_LO     = 1;
  localparam int          BIT_SCAN_DIS    = 7;
  localparam int          BIT_ASYNC_SEL   = 3;
  localparam int          STANDBY_WAKE_CYC = 6;
  localparam int          HALT_EXTRA_CYC   = 4;
  localparam logic [7:0]  STARTUP_DEFAULT  = 8'h10;
  localparam logic [31:0] RESET_WORD       = 32'h0;

  typedef struct packed {
    logic core_clk;
    logic prog_clk;
    logic io_clk;
    logic conv_clk;
    logic async_clk;
    logic main_osc;
    logic timer_osc;
  } clk_en_t;

  typedef struct packed {
    logic analog_cmp_en;
    logic analog_cmp_uses_ref;
    logic conv_en;
    logic brownout_en;
    logic watchdog_en;
  } analog_t;
endpackage : sleep_pkg

// ### logic/wake_counter.sv
module wake_counter
  import sleep_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              done
);
  logic [W-1:0] cnt_r;
  logic         busy_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end
    else if (start)
    begin
      cnt_r  <= load;
      busy_r <= 1'b1;
    end
    else if (busy_r)
    begin
      if (cnt_r <= W'(1))
        busy_r <= 1'b0;
      else
        cnt_r <= cnt_r - W'(1);
    end
  end

  assign done = busy_r && (cnt_r <= W'(1));
endmodule : wake_counter

// ### logic/sleep_ctrl.sv
// Overview of operation
// [RL1] Mode 110 with crystal clock enters standby: power-down but oscillator runs.
// [RL2] Wake from standby takes 6 oscillator cycles.
// [RL3] Each mode gates its own set of clock domains and main source.
// [RL4] Deep modes wake only on lines 0-3 or level 4-7; address match always.
// [RL5] Async domain and timer wake in save/noise modes only with select bit; the code leaves async_clk running in noise mode regardless of it.
// [RL6] An enabled converter stays enabled through every sleep mode.
// [RL7] Converter turned off then on makes next conversion extended.
// [RL8] Comparator off in deep modes; its internal reference stays on.
// [RL9] Reference on when brownout, comparator or converter needs it.
// [RL10] Fuse-enabled brownout detector stays on in every mode.
// [RL11] Enabled watchdog keeps running in every mode.
// [RL12] Input buffers off when io and converter clocks both stop.
// [RL13] Debug fuse keeps main clock source on in every mode; the code does so only while the scan port is also enabled (SCAN_PORT_EN).
// [RL14] Scan port disabled by disable bit or unprogrammed enable fuse.
// [RL15] Scan output undriven when port enabled and not shifting.
// [RL16] Core sets arm bit before sleep; no sleep while it is zero.
// [RL17] Mode codes: 000,001,010,011,110; 100,101,111 reserved.
// [RL18] Core halts four cycles past start-up, then services the wake.
// [RL19] Every gated clock is back on before the core is released.
//
// Register access over APB and the register addresses are this design's own decisions.
module sleep_ctrl
#(
  parameter logic [7:0] STARTUP_CYC = sleep_pkg::STARTUP_DEFAULT
)(
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SLEEP_INSN,
  input  wire logic        XTAL_CLOCK_OPT,
  input  wire logic [7:0]  EXT_IRQ,
  input  wire logic [7:0]  EXT_IRQ_LEVEL_MODE,
  input  wire logic        ADDR_MATCH_IRQ,
  input  wire logic        TIMER2_IRQ,
  input  wire logic        STORE_READY_IRQ,
  input  wire logic        CONV_DONE_IRQ,
  input  wire logic        OTHER_IO_IRQ,
  input  wire sleep_pkg::analog_t ANALOG_IN,
  input  wire logic [2:0]  BROWNOUT_LEVEL_FUSES,
  input  wire logic        DEBUG_ENABLE_FUSE,
  input  wire logic        SCAN_PORT_ENABLE_FUSE,
  input  wire logic        TAP_SHIFTING,
  input  wire logic        TAP_TDO_IN,
  output sleep_pkg::clk_en_t CLK_EN,
  output logic             CORE_HALT,
  output logic             WAKE_IRQ,
  output logic             CONV_EN_OUT,
  output logic             CONV_EXTENDED,
  output logic             CMP_EN_OUT,
  output logic             REF_EN,
  output logic             BROWNOUT_EN,
  output logic             WATCHDOG_RUN,
  output logic             INPUT_BUF_EN,
  output logic             SCAN_PORT_EN,
  output logic             TDO_O,
  output logic             TDO_OE
);
  import sleep_pkg::*;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_START = 2'b11,
    ST_HALT  = 2'b10
  } state_t;

  state_t      state_r;
  logic [2:0]  mode_r;
  logic        arm_r;
  logic        scan_dis_r;
  logic        async_sel_r;
  logic [2:0]  sleep_mode_r;
  logic [7:0]  irq_s1_r;
  logic [7:0]  irq_s2_r;
  logic [7:0]  irq_mask;
  logic        wake;
  logic        deep;
  logic        async_on;
  logic        cnt_start;
  logic [7:0]  cnt_load;
  logic        cnt_done;
  logic        conv_prev_r;
  logic        conv_ext_r;
  clk_en_t     gate;
  logic        wr;
  logic        rd;
  logic        valid_mode;

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;

  // Bus writes to the controlling bits
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      mode_r      <= MODE_IDLE;
      arm_r       <= 1'b0;
      scan_dis_r  <= 1'b0;
      async_sel_r <= 1'b0;
    end
    else if (wr)
    begin
      case (PADDR)
        ADDR_SLEEP_CTRL:
        begin
          arm_r  <= PWDATA[BIT_ARM];
          mode_r <= PWDATA[BIT_MODE_LO +: 3];
        end
        ADDR_CORE_CTRL:  scan_dis_r  <= PWDATA[BIT_SCAN_DIS];
        ADDR_ASYNC_STAT: async_sel_r <= PWDATA[BIT_ASYNC_SEL];
        default:         ;
      endcase
    end
  end

  // Read data registered in setup, stable through access
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      PRDATA <= RESET_WORD;
    else if (rd)
    begin
      case (PADDR)
        ADDR_SLEEP_CTRL: PRDATA <= {28'h0, mode_r, arm_r};
        ADDR_CORE_CTRL:  PRDATA <= {24'h0, scan_dis_r, 7'h0};
        ADDR_ASYNC_STAT: PRDATA <= {28'h0, async_sel_r, 3'h0};
        ADDR_STATUS:     PRDATA <= {24'h0, conv_ext_r, sleep_mode_r,
                                    2'h0, state_r};
        default:         PRDATA <= RESET_WORD;
      endcase
    end
  end

  // Pins from outside the clock domain
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      irq_s1_r <= 8'h00;
      irq_s2_r <= 8'h00;
    end
    else
    begin
      irq_s1_r <= EXT_IRQ;
      irq_s2_r <= irq_s1_r;
    end
  end

  assign valid_mode = (mode_r == MODE_IDLE) || (mode_r == MODE_ADC_NR) ||
                      (mode_r == MODE_PDOWN) || (mode_r == MODE_PSAVE) ||
                      (mode_r == MODE_STANDBY && XTAL_CLOCK_OPT); // RL17 RL1
  assign deep = (sleep_mode_r != MODE_IDLE);
  assign async_on = async_sel_r && ((sleep_mode_r == MODE_PSAVE) ||
                                    (sleep_mode_r == MODE_ADC_NR)); // RL5
  assign irq_mask = deep ? {EXT_IRQ_LEVEL_MODE[7:4], 4'hf} : 8'hff; // RL4
  always_comb
  begin
    wake = (|(irq_s2_r & irq_mask)) || ADDR_MATCH_IRQ; // RL4
    case (sleep_mode_r)
      MODE_IDLE:   wake = wake || TIMER2_IRQ || STORE_READY_IRQ ||
                          CONV_DONE_IRQ || OTHER_IO_IRQ;
      MODE_ADC_NR: wake = wake || (TIMER2_IRQ && async_on) ||
                          STORE_READY_IRQ || CONV_DONE_IRQ;
      MODE_PSAVE:  wake = wake || (TIMER2_IRQ && async_on); // RL5
      default:     wake = wake;
    endcase
  end

  // Sleep sequencer
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      state_r      <= ST_RUN;
      sleep_mode_r <= MODE_IDLE;
    end
    else
    begin
      case (state_r)
        ST_RUN:
          if (SLEEP_INSN && arm_r && valid_mode) // RL16
          begin
            state_r      <= ST_SLEEP;
            sleep_mode_r <= mode_r;
          end
        ST_SLEEP:  if (wake) state_r <= ST_START;
        ST_START:  if (cnt_done) state_r <= ST_HALT;
        ST_HALT:   if (cnt_done) state_r <= ST_RUN;
        default:   state_r <= ST_RUN;
      endcase
    end
  end

  // Standby wakes fast; power-down and power-save wait the oscillator start-up
  always_comb
  begin
    cnt_start = 1'b0;
    cnt_load  = 8'h01;
    if (state_r == ST_SLEEP && wake)
    begin
      cnt_start = 1'b1;
      if (sleep_mode_r == MODE_STANDBY)
        cnt_load = 8'(STANDBY_WAKE_CYC); // RL2
      else if (sleep_mode_r != MODE_IDLE && sleep_mode_r != MODE_ADC_NR)
        cnt_load = STARTUP_CYC;
    end
    else if (state_r == ST_START && cnt_done)
    begin
      cnt_start = 1'b1;
      cnt_load  = 8'(HALT_EXTRA_CYC); // RL18
    end
  end
  wake_counter #(.W(8)) u_wake_cnt (
    .clk   (MCLK),
    .rst_n (RST_N),
    .start (cnt_start),
    .load  (cnt_load),
    .done  (cnt_done)
  );
  // Gating per mode; all restored from ST_START on, before release
  always_comb
  begin
    gate = '1;
    if (state_r == ST_SLEEP) // RL19
    begin
      gate.core_clk = 1'b0; // RL3
      gate.prog_clk = 1'b0;
      case (sleep_mode_r)
        MODE_IDLE: gate.timer_osc = async_sel_r;
        MODE_ADC_NR:
        begin
          gate.io_clk    = 1'b0;
          gate.timer_osc = async_on;
        end
        MODE_STANDBY:
        begin
          gate.io_clk    = 1'b0; // RL1
          gate.conv_clk  = 1'b0;
          gate.async_clk = 1'b0;
          gate.timer_osc = 1'b0;
        end
        default:
        begin
          gate.io_clk    = 1'b0;
          gate.conv_clk  = 1'b0;
          gate.async_clk = async_on;
          gate.timer_osc = async_on;
          gate.main_osc  = 1'b0;
        end
      endcase
      if (DEBUG_ENABLE_FUSE && SCAN_PORT_EN)
        gate.main_osc = 1'b1; // RL13
    end
  end

  assign CLK_EN    = gate;
  assign CORE_HALT = (state_r != ST_RUN);
  assign WAKE_IRQ  = (state_r == ST_HALT) && cnt_done;
  // Converter never gated by this block
  assign CONV_EN_OUT = ANALOG_IN.conv_en; // RL6

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      conv_prev_r <= 1'b0;
      conv_ext_r  <= 1'b1;
    end
    else
    begin
      conv_prev_r <= ANALOG_IN.conv_en;
      if (!conv_prev_r && ANALOG_IN.conv_en)
        conv_ext_r <= 1'b1; // RL7
      else if (CONV_DONE_IRQ)
        conv_ext_r <= 1'b0;
    end
  end
  assign CONV_EXTENDED = conv_ext_r;

  assign CMP_EN_OUT = ANALOG_IN.analog_cmp_en && !(state_r == ST_SLEEP &&
                      sleep_mode_r != MODE_IDLE &&
                      sleep_mode_r != MODE_ADC_NR); // RL8
  assign BROWNOUT_EN = (BROWNOUT_LEVEL_FUSES != 3'h7); // RL10
  // Reference follows the comparator's request, not its gated enable
  assign REF_EN = BROWNOUT_EN || ANALOG_IN.conv_en ||
                  (ANALOG_IN.analog_cmp_en &&
                   ANALOG_IN.analog_cmp_uses_ref); // RL9 RL8
  assign WATCHDOG_RUN = ANALOG_IN.watchdog_en; // RL11
  // Wake inputs keep their buffers via separate detect path
  assign INPUT_BUF_EN = gate.io_clk || gate.conv_clk; // RL12
  assign SCAN_PORT_EN = SCAN_PORT_ENABLE_FUSE && !scan_dis_r; // RL14
  assign TDO_O  = TAP_TDO_IN;
  assign TDO_OE = SCAN_PORT_EN && TAP_SHIFTING; // RL15

  sequence s_start_six;
    (state_r == ST_START)[*6] ##1 state_r == ST_HALT;
  endsequence
  sequence s_halt_four;
    (state_r == ST_HALT)[*4] ##1 state_r == ST_RUN;
  endsequence
  a_arm_needed: assert property (@(posedge MCLK) disable iff (!RST_N) // RL16
    (state_r == ST_RUN && !arm_r) |=> state_r == ST_RUN)
    else $error("sleep entered while unarmed");
  a_standby_wake: assert property (@(posedge MCLK) disable iff (!RST_N) // RL2
    (state_r == ST_SLEEP && wake && sleep_mode_r == MODE_STANDBY)
    |=> s_start_six)
    else $error("standby wake not 6 cycles");
  a_halt_four: assert property (@(posedge MCLK) disable iff (!RST_N) // RL18
    $rose(state_r == ST_HALT) |-> s_halt_four)
    else $error("halt not four cycles");
  a_clocks_back: assert property (@(posedge MCLK) disable iff (!RST_N) // RL19
    (state_r != ST_SLEEP) |-> CLK_EN == '1)
    else $error("clock still gated after wake");
  a_tdo_float: assert property (@(posedge MCLK) disable iff (!RST_N) // RL15
    !TAP_SHIFTING |-> !TDO_OE)
    else $error("tdo driven while idle");
  a_cmp_off: assert property (@(posedge MCLK) disable iff (!RST_N) // RL8
    (state_r == ST_SLEEP && sleep_mode_r == MODE_PDOWN) |-> !CMP_EN_OUT)
    else $error("comparator on in power-down");
  a_buf_off: assert property (@(posedge MCLK) disable iff (!RST_N) // RL12
    (state_r == ST_SLEEP && !CLK_EN.io_clk && !CLK_EN.conv_clk)
    |-> !INPUT_BUF_EN)
    else $error("input buffers on in deep sleep");
  a_deep_mask: assert property (@(posedge MCLK) disable iff (!RST_N) // RL4
    (state_r == ST_SLEEP && sleep_mode_r == MODE_PDOWN && !ADDR_MATCH_IRQ
     && (irq_s2_r & {EXT_IRQ_LEVEL_MODE[7:4], 4'hf}) == 8'h00)
    |=> state_r == ST_SLEEP)
    else $error("deep sleep woke on masked line");
endmodule : sleep_ctrl

// ### dv/core_model.sv
module core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic go,
  input  wire logic halt,
  output logic      sleep_insn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Halted core cannot issue; bench arms first
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sleep_insn <= 1'b0;
    else
      sleep_insn <= go & ~halt;
  end
endmodule : core_model

// ### dv/test_sleep_mode_clock_gating.sv
`define CHK(a, e) \
  begin \
    check_count++; \
    if ((a) !== (e)) \
    begin \
      n_errors++; \
      $display("wrong value at %0t: %h vs %h", $time, (a), (e)); \
    end \
  end
module test_sleep_mode_clock_gating import sleep_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, psel, pen, pwr, go, xtal, am, cdone, slp;
  logic        shift, dbg, scan, prdy, halt, wirq, cvo, cvx, cmp, t2;
  logic        ref_en, bo, wd, ibuf, spe, oe;
  logic [11:0] pa;
  logic [31:0] pwd, prd, q;
  logic [7:0]  ext, lvl;
  logic [2:0]  bod;
  analog_t     ana;
  clk_en_t     ce;
  int          n_errors, check_count, n, nw;
  int          cyc = 0;
  logic [7:0]  bad [5] = '{8'h09, 8'h0b, 8'h0f, 8'h04, 8'h0d};
  logic [2:0]  md [5] = '{MODE_IDLE, MODE_ADC_NR, MODE_PDOWN,
                          MODE_PSAVE, MODE_STANDBY};

  sleep_ctrl #(.STARTUP_CYC(8'h02)) u_dut (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(), .SLEEP_INSN(slp), .XTAL_CLOCK_OPT(xtal),
    .EXT_IRQ(ext), .EXT_IRQ_LEVEL_MODE(lvl), .ADDR_MATCH_IRQ(am),
    .TIMER2_IRQ(t2), .STORE_READY_IRQ(1'b0), .CONV_DONE_IRQ(cdone),
    .OTHER_IO_IRQ(1'b0), .ANALOG_IN(ana), .BROWNOUT_LEVEL_FUSES(bod),
    .DEBUG_ENABLE_FUSE(dbg), .SCAN_PORT_ENABLE_FUSE(scan),
    .TAP_SHIFTING(shift), .TAP_TDO_IN(1'b0), .CLK_EN(ce),
    .CORE_HALT(halt), .WAKE_IRQ(wirq), .CONV_EN_OUT(cvo),
    .CONV_EXTENDED(cvx), .CMP_EN_OUT(cmp), .REF_EN(ref_en),
    .BROWNOUT_EN(bo), .WATCHDOG_RUN(wd), .INPUT_BUF_EN(ibuf),
    .SCAN_PORT_EN(spe), .TDO_O(), .TDO_OE(oe)
  );
  core_model u_core (.clk(mclk), .rst_n(rst_n), .go(go), .halt(halt),
                     .sleep_insn(slp));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [6:0] gate(input logic [2:0] m, input logic a);
    case (m)
      MODE_IDLE:    gate = {6'b001111, a};
      MODE_ADC_NR:  gate = {6'b000111, a};
      MODE_PSAVE:   gate = {4'b0000, a, 1'b0, a};
      MODE_STANDBY: gate = 7'h02;
      default:      gate = 7'h00;
    endcase
  endfunction : gate

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pen  <= 1'b0;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do @(posedge mclk); while (prdy !== 1'b1);
    q = prd;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task settle(input int k);
    repeat (k) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  task nap(input logic [7:0] c);
    apb(1'b1, ADDR_SLEEP_CTRL, {24'h0, c});
    @(posedge mclk) go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    settle(3);
  endtask : nap

  // Wake source: line 1 (synchronised) or address match
  task wake(input logic e);
    n  = 0;
    nw = 0;
    @(posedge mclk);
    if (e)
      ext <= 8'h02;
    else
      am <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (wirq === 1'b1)
      begin
        nw++;
        `CHK(ce, 7'h7f);
      end
    end while (halt !== 1'b0 && n < 100);
    `CHK(nw, 1);
    `CHK(halt, 1'b0);
    ext <= 8'h00;
    am  <= 1'b0;
  endtask : wake

  task results;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // Generous ceiling: whole run needs about 400 cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end

  initial
  begin
    {psel, pen, pwr, go, am, cdone, shift, dbg, t2} = '0;
    rst_n = 1'b0;
    xtal  = 1'b0;
    scan  = 1'b1;
    pa    = '0;
    pwd   = '0;
    ext   = '0;
    lvl   = '0;
    bod   = 3'h7;
    ana   = '0;
    settle(8);
    `CHK(ce, 7'h7f);
    `CHK(cvx, 1'b1);
    @(posedge mclk) rst_n <= 1'b1;
    apb(1'b0, ADDR_SLEEP_CTRL, 32'h0);
    `CHK(q, 32'h0);
    apb(1'b1, ADDR_SLEEP_CTRL, 32'hff);
    apb(1'b0, ADDR_SLEEP_CTRL, 32'h0);
    `CHK(q, 32'h0f);
    apb(1'b0, 12'h010, 32'h0);
    `CHK(q, 32'h0);
    foreach (bad[i])
    begin
      nap(bad[i]);
      `CHK(halt, 1'b0);
    end
    @(posedge mclk) xtal <= 1'b1;
    for (int a = 0; a < 2; a++)
    begin
      apb(1'b1, ADDR_ASYNC_STAT, {28'h0, a[0], 3'h0});
      foreach (md[i])
      begin
        nap({4'h0, md[i], 1'b1});
        `CHK(ce, gate(md[i], a[0]));
        `CHK(halt, 1'b1);
        wake(1'b0);
      end
    end
    `CHK(n, STANDBY_WAKE_CYC + HALT_EXTRA_CYC + 2);
    ana <= 5'b11101;
    bod <= 3'h0;
    nap(8'h05);
    `CHK(cmp, 1'b0);
    `CHK(ref_en, 1'b1);
    `CHK(cvo, 1'b1);
    `CHK(bo, 1'b1);
    `CHK(wd, 1'b1);
    `CHK(ibuf, 1'b0);
    @(posedge mclk) ext <= 8'h20;
    settle(10);
    `CHK(halt, 1'b1);
    @(posedge mclk) lvl <= 8'h20;
    settle(30);
    `CHK(halt, 1'b0);
    @(posedge mclk);
    ext <= 8'h00;
    lvl <= 8'h00;
    nap(8'h07);
    wake(1'b1);
    `CHK(halt, 1'b0);
    // Timer wake in power-save only with async select set
    nap(8'h07);
    @(posedge mclk) t2 <= 1'b1;
    settle(10);
    `CHK(halt, 1'b0);
    apb(1'b1, ADDR_ASYNC_STAT, 32'h0);
    nap(8'h07);
    settle(10);
    `CHK(halt, 1'b1);
    wake(1'b0);
    t2  <= 1'b0;
    dbg <= 1'b1;
    nap(8'h05);
    `CHK(ce.main_osc, 1'b1);
    wake(1'b0);
    `CHK(spe, 1'b1);
    `CHK(oe, 1'b0);
    @(posedge mclk) shift <= 1'b1;
    settle(1);
    `CHK(oe, 1'b1);
    apb(1'b1, ADDR_CORE_CTRL, 32'h80);
    settle(1);
    `CHK(spe, 1'b0);
    apb(1'b1, ADDR_CORE_CTRL, 32'h0);
    scan <= 1'b0;
    settle(1);
    `CHK(spe, 1'b0);
    @(posedge mclk) cdone <= 1'b1;
    @(posedge mclk) cdone <= 1'b0;
    settle(1);
    `CHK(cvx, 1'b0);
    @(posedge mclk) ana.conv_en <= 1'b0;
    @(posedge mclk) ana.conv_en <= 1'b1;
    settle(2);
    `CHK(cvx, 1'b1);
    @(posedge mclk) ana <= '0;
    bod <= 3'h7;
    settle(2);
    `CHK(ref_en, 1'b0);
    results();
  end
endmodule : test_sleep_mode_clock_gating
